// [rtl/rst_ctrl_pkg.sv]
// Constants shared by the receive and physical-layer reset controller.
package rst_ctrl_pkg;
  // Control register one bit positions.
  localparam int unsigned RX_RESET_POS = 6;
  localparam int unsigned RX_ENABLE_POS = 2;
  // Physical-layer control register one field positions.
  localparam int unsigned PHY_RESET_POS = 15;
  localparam int unsigned PHY_LOOP_POS = 14;
  localparam int unsigned PHY_PWRDN_POS = 11;
  localparam int unsigned PHY_RSV_HI_POS = 10;
  localparam int unsigned PHY_DUPLEX_POS = 8;
  localparam int unsigned PHY_RSV_LO_POS = 7;
  // Readable bit mask; all other bits read zero.
  localparam logic [15:0] PHY_READ_MASK = 16'hc900;
  localparam logic [15:0] PHY_CTRL_RESET = 16'h0000;
  // Physical-layer reset settling time and its count at a 5 ns clock.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned PHY_RST_TIME_NS = 1000;
  localparam int unsigned PHY_RST_CYCLES = (PHY_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int unsigned PHY_CNT_W = 16;
endpackage : rst_ctrl_pkg

// [rtl/rx_and_phy_reset_control.sv]
// Receive-only reset and physical-layer control register with self-clearing soft reset.
//
// Overview of operation
// [R01] Writing one to receive reset bit resets only the receive logic.
// [R02] Receive enable is cleared by hardware when receive reset becomes set.
// [R03] A frame in reception is aborted at once on receive reset.
// [R04] System reset also applies the receive-only reset.
// [R05] Receive-only reset leaves every other register and unit untouched.
// [R06] Host clears receive reset bit to resume normal reception.
// [R07] Physical soft reset bit 15 returns physical registers to defaults.
// [R08] Soft reset bit reads one during reset, clears after internal delay.
// [R09] Host polls soft reset bit until zero before using physical layer.
// [R10] Loopback bit 14 returns transmit data and disables twisted pair.
// [R11] Power-down bit 11 shuts physical layer down; clearing restores it.
// [R12] Duplex bit 8 selects full duplex when one, half when zero.
// [R13] Duplex reset value follows the second LED pin connection strap.
// [R14] Host writes zero to reserved bits 10 and 7.
// [R15] Bits 13-12, 9 and 6-0 always read zero.
// [R16] Host waits 50 microseconds after system reset before physical access.
// [R17] Receive logic held in reset while receive reset bit stays one.
// [R18] Soft reset delay is a parameterised counter clearing the bit.
`timescale 1ns/1ps
`default_nettype none

module rx_and_phy_reset_control #(
  parameter int unsigned PHY_RST_DELAY = rst_ctrl_pkg::PHY_RST_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  // Control register one write strobe, data and readback.
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // Physical-layer control register one write strobe, data and readback.
  input wire logic phy_wr,
  input wire logic [15:0] phy_wdata,
  output logic [15:0] phy_rdata,
  // Level of the second LED pin, seen as the duplex strap.
  input wire logic second_led_pin,
  // Receive datapath status.
  input wire logic rx_frame_active,
  // Outputs to the receive and physical-layer logic.
  output logic rx_logic_reset,
  output logic rx_frame_abort,
  output logic rx_enable,
  output logic phy_reset_active,
  output logic phy_loopback,
  output logic twisted_pair_enable,
  output logic phy_power_down,
  output logic phy_full_duplex
);

  logic rx_reset_ff, nxt_rx_reset;
  logic rx_enable_ff, nxt_rx_enable;
  logic [5:0] ctrl_other_ff, nxt_ctrl_other;
  logic abort_ff, nxt_abort;
  logic phy_reset_ff, nxt_phy_reset;
  logic loop_ff, nxt_loop;
  logic pwrdn_ff, nxt_pwrdn;
  logic duplex_ff, nxt_duplex;
  logic strap_pend_ff, nxt_strap_pend;
  logic [rst_ctrl_pkg::PHY_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic rst_q_ff;
  logic phy_wr_take;

  localparam logic [rst_ctrl_pkg::PHY_CNT_W-1:0] DELAY_LAST =
    rst_ctrl_pkg::PHY_CNT_W'(PHY_RST_DELAY - 1);

  // Control register one: receive reset and receive enable, plus other bits kept as storage.
  always_comb begin
    nxt_rx_reset = rx_reset_ff;
    nxt_rx_enable = rx_enable_ff;
    nxt_ctrl_other = ctrl_other_ff;
    nxt_abort = 1'b0;
    if (ctrl_wr) begin
      // [R17] write sets or clears
      nxt_rx_reset = ctrl_wdata[rst_ctrl_pkg::RX_RESET_POS];
      nxt_rx_enable = ctrl_wdata[rst_ctrl_pkg::RX_ENABLE_POS];
      nxt_ctrl_other = {ctrl_wdata[7], ctrl_wdata[5:3], ctrl_wdata[1:0]};
    end
    // [R02] enable cleared by hardware
    if (nxt_rx_reset) begin
      nxt_rx_enable = 1'b0;
    end
    // [R03] abort in-progress frame
    if (ctrl_wr && ctrl_wdata[rst_ctrl_pkg::RX_RESET_POS] && !rx_reset_ff && rx_frame_active) begin
      nxt_abort = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_reset_ff <= 1'b0;
      rx_enable_ff <= 1'b0;
      ctrl_other_ff <= 6'h00;
      abort_ff <= 1'b0;
      rst_q_ff <= 1'b1;
    end else begin
      rx_reset_ff <= nxt_rx_reset;
      rx_enable_ff <= nxt_rx_enable;
      ctrl_other_ff <= nxt_ctrl_other;
      abort_ff <= nxt_abort;
      rst_q_ff <= 1'b0;
    end
  end

  // [R01] receive-only reset output
  // [R04] system reset drives it too
  // [R17] held while bit is one
  assign rx_logic_reset = srst | rx_reset_ff;
  assign rx_frame_abort = abort_ff;
  assign rx_enable = rx_enable_ff;
  assign ctrl_rdata = {ctrl_other_ff[5], rx_reset_ff, ctrl_other_ff[4:2], rx_enable_ff,
                       ctrl_other_ff[1:0]};

  // Physical-layer control register; the duplex strap is caught one cycle after release.
  always_comb begin
    nxt_phy_reset = phy_reset_ff;
    nxt_loop = loop_ff;
    nxt_pwrdn = pwrdn_ff;
    nxt_duplex = duplex_ff;
    nxt_strap_pend = 1'b0;
    nxt_cnt = cnt_ff;
    if (rst_q_ff) begin
      // [R13] duplex default from strap
      nxt_duplex = second_led_pin;
    end else if (phy_reset_ff) begin
      // [R18] delay counter clears bit
      if (cnt_ff == DELAY_LAST) begin
        nxt_phy_reset = 1'b0;
        nxt_cnt = '0;
        nxt_strap_pend = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end else if (strap_pend_ff) begin
      nxt_duplex = second_led_pin;
    end else if (phy_wr) begin
      if (phy_wdata[rst_ctrl_pkg::PHY_RESET_POS]) begin
        // [R07] return to defaults
        nxt_phy_reset = 1'b1;
        nxt_loop = 1'b0;
        nxt_pwrdn = 1'b0;
        nxt_cnt = '0;
      end else begin
        // [R10] loopback select
        nxt_loop = phy_wdata[rst_ctrl_pkg::PHY_LOOP_POS];
        // [R11] power-down select
        nxt_pwrdn = phy_wdata[rst_ctrl_pkg::PHY_PWRDN_POS];
        // [R12] duplex select
        nxt_duplex = phy_wdata[rst_ctrl_pkg::PHY_DUPLEX_POS];
      end
    end
  end

  // [R05] only system reset clears
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phy_reset_ff <= 1'b0;
      loop_ff <= 1'b0;
      pwrdn_ff <= 1'b0;
      duplex_ff <= 1'b0;
      strap_pend_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      phy_reset_ff <= nxt_phy_reset;
      loop_ff <= nxt_loop;
      pwrdn_ff <= nxt_pwrdn;
      duplex_ff <= nxt_duplex;
      strap_pend_ff <= nxt_strap_pend;
      cnt_ff <= nxt_cnt;
    end
  end

  // [R08] bit reads one during reset
  // [R15] unimplemented bits read zero
  assign phy_rdata = {phy_reset_ff, loop_ff, 2'b00, pwrdn_ff, 2'b00, duplex_ff, 8'h00}
                     & rst_ctrl_pkg::PHY_READ_MASK;
  assign phy_reset_active = phy_reset_ff;
  assign phy_loopback = loop_ff;
  // [R10] twisted pair off in loopback
  assign twisted_pair_enable = !loop_ff && !pwrdn_ff && !phy_reset_ff;
  assign phy_power_down = pwrdn_ff;
  assign phy_full_duplex = duplex_ff;

  // A physical-layer write is taken only outside soft reset and strap loading.
  assign phy_wr_take = phy_wr && !phy_reset_ff && !rst_q_ff && !strap_pend_ff;

  // Assertions.
  a_rx_en_clear: assert property (@(posedge ref_clk) disable iff (srst) // [R02]
    rx_reset_ff |-> !rx_enable_ff) else $error("receive enable set during receive reset");

  a_rx_hold: assert property (@(posedge ref_clk) disable iff (srst) // [R17]
    $fell(rx_reset_ff) |-> !rx_logic_reset) else $error("receive reset not released");

  a_rx_sys: assert property (@(posedge ref_clk) // [R04]
    srst |-> rx_logic_reset) else $error("system reset missed receive logic");

  a_rx_abort: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    (ctrl_wr && ctrl_wdata[6] && !rx_reset_ff && rx_frame_active) |=> rx_frame_abort)
    else $error("frame not aborted");

  a_rx_only: assert property (@(posedge ref_clk) disable iff (srst) // [R05]
    ($rose(rx_reset_ff) && !$past(phy_wr) && !$past(phy_reset_ff) && !$past(strap_pend_ff)
     && !$past(rst_q_ff)) |-> $stable(phy_rdata))
    else $error("receive reset disturbed physical register");

  // A host write that sets the receive reset bit.
  sequence rx_set_s;
    ctrl_wr && ctrl_wdata[rst_ctrl_pkg::RX_RESET_POS];
  endsequence

  // A host write that clears a receive reset bit that is set.
  sequence rx_clear_s;
    ctrl_wr && !ctrl_wdata[rst_ctrl_pkg::RX_RESET_POS] && rx_reset_ff;
  endsequence

  // A soft reset whose delay counter has not yet run out.
  sequence phy_busy_s;
    phy_reset_ff && (cnt_ff != DELAY_LAST);
  endsequence

  // The receive logic enters reset on the cycle after the bit is written.
  a_rx_set_take: assert property (@(posedge ref_clk) disable iff (srst) // [R01]
    rx_set_s |=> (rx_logic_reset && !rx_enable))
    else $error("receive reset write not taken");

  // Clearing the bit releases the receive logic on the next cycle.
  a_rx_release: assert property (@(posedge ref_clk) disable iff (srst) // [R17]
    rx_clear_s |=> !rx_logic_reset)
    else $error("receive reset not released after clear");

  // Without a write the receive reset stays in force.
  a_rx_held: assert property (@(posedge ref_clk) disable iff (srst) // [R17]
    (rx_reset_ff && !ctrl_wr) |=> rx_logic_reset)
    else $error("receive reset dropped without a write");

  // The abort strobe lasts a single cycle.
  a_abort_pulse: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    rx_frame_abort |=> !rx_frame_abort)
    else $error("frame abort longer than one cycle");

  // Only a host write can abort a frame.
  a_abort_quiet: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    !ctrl_wr |=> !rx_frame_abort)
    else $error("frame abort without a write");

  // The soft reset bit stays set until the counter runs out.
  a_phy_busy: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    phy_busy_s |=> phy_reset_active)
    else $error("soft reset ended before its delay");

  // Writes during a soft reset leave the control bits alone.
  a_phy_refuse: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    (phy_wr && phy_reset_ff) |=>
    ($stable(phy_loopback) && $stable(phy_power_down) && $stable(phy_full_duplex)))
    else $error("write taken during soft reset");

  // After a soft reset the duplex mode is loaded again from the strap.
  a_phy_reload: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
    strap_pend_ff |=> phy_full_duplex == $past(second_led_pin))
    else $error("duplex strap not reloaded after soft reset");

  // A taken write sets the loopback mode.
  a_phy_loop_take: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
    (phy_wr_take && !phy_wdata[rst_ctrl_pkg::PHY_RESET_POS])
    |=> phy_loopback == $past(phy_wdata[rst_ctrl_pkg::PHY_LOOP_POS]))
    else $error("loopback not taken");

  // A shut-down physical layer keeps the twisted pair off.
  a_pwr_tp_off: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
    phy_power_down |-> !twisted_pair_enable)
    else $error("twisted pair on in power-down");

  // A taken soft reset write starts the reset and turns the twisted pair off.
  a_phy_reset_start: assert property (@(posedge ref_clk) disable iff (srst) // [R07]
    (phy_wr_take && phy_wdata[rst_ctrl_pkg::PHY_RESET_POS])
    |=> (phy_reset_active && !twisted_pair_enable))
    else $error("soft reset not started");

  sequence phy_req_s;
    phy_wr && phy_wdata[15] && !phy_reset_ff && !rst_q_ff && !strap_pend_ff;
  endsequence

  a_phy_hold: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    phy_req_s |=> phy_rdata[15] [*2]) else $error("soft reset bit cleared too early");

  a_phy_defaults: assert property (@(posedge ref_clk) disable iff (srst) // [R07]
    phy_req_s |=> (!phy_loopback && !phy_power_down)) else $error("defaults not restored");

  a_phy_done: assert property (@(posedge ref_clk) disable iff (srst) // [R18]
    (phy_reset_ff && cnt_ff == DELAY_LAST) |=> !phy_reset_ff) else $error("counter did not end reset");

  a_phy_zero: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
    (phy_rdata & ~rst_ctrl_pkg::PHY_READ_MASK) == 16'h0000) else $error("unimplemented bit set");

  a_phy_loop: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
    phy_loopback |-> !twisted_pair_enable) else $error("twisted pair on in loopback");

  a_phy_pwr: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
    (phy_wr && !phy_reset_ff && !rst_q_ff && !strap_pend_ff && !phy_wdata[15])
    |=> phy_power_down == $past(phy_wdata[11])) else $error("power-down not taken");

  a_phy_duplex: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    (phy_wr && !phy_reset_ff && !rst_q_ff && !strap_pend_ff && !phy_wdata[15])
    |=> phy_full_duplex == $past(phy_wdata[8])) else $error("duplex not taken");

  a_phy_strap: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
    rst_q_ff |=> phy_full_duplex == $past(second_led_pin)) else $error("duplex strap not caught");

endmodule : rx_and_phy_reset_control

`default_nettype wire

// [verif/host_model.sv]
// Host model that writes both control registers and polls the soft reset bit.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output var logic ctrl_wr,
  output var logic [7:0] ctrl_wdata,
  output var logic phy_wr,
  output var logic [15:0] phy_wdata,
  input wire logic [15:0] phy_rdata
);
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    phy_wr = 1'b0;
    phy_wdata = 16'h0000;
  end
  task automatic wr_ctrl(input logic [7:0] d);
    @(negedge ref_clk);
    ctrl_wdata = d;
    ctrl_wr = 1'b1;
    @(negedge ref_clk);
    ctrl_wr = 1'b0;
  endtask : wr_ctrl
  task automatic wr_phy(input logic [15:0] d);
    @(negedge ref_clk);
    phy_wdata = d & 16'hfb7f;
    phy_wr = 1'b1;
    @(negedge ref_clk);
    phy_wr = 1'b0;
  endtask : wr_phy
  task automatic poll_phy(output int n);
    n = 0;
    while (phy_rdata[15] !== 1'b0 && n < 1000) begin
      n++;
      @(negedge ref_clk);
    end
  endtask : poll_phy
endmodule : host_model
`default_nettype wire

// [verif/rx_and_phy_reset_control_tb.sv]
// Self-checking bench for the receive and physical-layer reset controller.
`timescale 1ns/1ps
`default_nettype none
module rx_and_phy_reset_control_tb;
  localparam int unsigned DLY = 4;
  logic ref_clk, srst, cwr, pwr, led, rx_act;
  logic [7:0] cwd, crd;
  logic [15:0] pwd, prd;
  logic rx_rst, abrt, rx_en, p_act, loop, tp_en, pdn, fdx;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  rx_and_phy_reset_control #(.PHY_RST_DELAY(DLY)) i_rx_and_phy_reset_control (
    .ref_clk(ref_clk), .srst(srst), .ctrl_wr(cwr), .ctrl_wdata(cwd), .ctrl_rdata(crd),
    .phy_wr(pwr), .phy_wdata(pwd), .phy_rdata(prd), .second_led_pin(led),
    .rx_frame_active(rx_act), .rx_logic_reset(rx_rst), .rx_frame_abort(abrt),
    .rx_enable(rx_en), .phy_reset_active(p_act), .phy_loopback(loop),
    .twisted_pair_enable(tp_en), .phy_power_down(pdn), .phy_full_duplex(fdx));
  host_model i_host_model (.ref_clk(ref_clk), .ctrl_wr(cwr), .ctrl_wdata(cwd),
    .phy_wr(pwr), .phy_wdata(pwd), .phy_rdata(prd));
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic set_pins(input logic act, input logic strap);
    rx_act = act;
    led = strap;
  endtask : set_pins
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #150000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    set_pins(1'b0, 1'b1);
    repeat (12) @(negedge ref_clk);
    chk("rx_rst", 16'h1, rx_rst);
    srst = 1'b0;
    repeat (10000) @(negedge ref_clk);
    chk("phy_rd", 16'h0100, prd);
    i_host_model.wr_ctrl(8'h04);
    chk("rx_en", 16'h1, rx_en);
    set_pins(1'b1, 1'b1);
    i_host_model.wr_ctrl(8'h44);
    chk("rst_en_abrt", 16'h5, {rx_rst, rx_en, abrt});
    chk("ctrl_rd", 16'h40, crd);
    chk("phy_keep", 16'h0100, prd);
    @(negedge ref_clk);
    chk("rst_abrt", 16'h2, {rx_rst, abrt});
    set_pins(1'b0, 1'b1);
    i_host_model.wr_ctrl(8'h00);
    chk("rx_rst", 16'h0, rx_rst);
    i_host_model.wr_phy(16'h4900);
    chk("phy_rd", 16'h4900, prd);
    chk("phy_out", 16'hb, {loop, tp_en, pdn, fdx});
    i_host_model.wr_phy(16'h327f);
    chk("phy_rd", 16'h0, prd);
    chk("phy_out", 16'h4, {loop, tp_en, pdn, fdx});
    i_host_model.wr_phy(16'h4100);
    set_pins(1'b0, 1'b0);
    i_host_model.wr_phy(16'h8000);
    chk("rst_act", 16'h2, {p_act, tp_en});
    i_host_model.poll_phy(n);
    chk("delay", 16'(DLY), 16'(n));
    repeat (2) @(negedge ref_clk);
    chk("phy_rd", 16'h0, prd);
    chk("phy_out", 16'h4, {loop, tp_en, pdn, fdx});
    i_host_model.wr_ctrl(8'h40);
    i_host_model.wr_phy(16'h4800);
    chk("mid_pre", 16'h3, {rx_rst, loop});
    set_pins(1'b0, 1'b1);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("mid_rst", 16'h1, rx_rst);
    srst = 1'b0;
    @(negedge ref_clk);
    chk("mid_ctrl", 16'h0, {rx_rst, crd});
    repeat (10000) @(negedge ref_clk);
    chk("mid_phy", 16'h0100, prd);
    chk("mid_out", 16'h5, {loop, tp_en, pdn, fdx});
    end_of_test();
  end
endmodule : rx_and_phy_reset_control_tb
`default_nettype wire
